// *** hw/tfieb_pkg.sv ***
// constants and carrier types for the filter interrupt enable bank
// assumes one system clock; registers sit at fixed offsets behind the host slave port
// Operation
// RL1: enable-low register holds error irq enables, filter channels 0..31 at bits 0..31, reset 0.
// RL2: enable-high register at 0x130 holds error enables for channels 32..63, reset 0.
// RL3: status at 0x134 holds eight capture flags; hardware sets, software writes 1 to clear.
// RL4: bits 31..8 of capture status and enable read zero; bits 7..0 reset 0.
// RL5: enable at 0x138 holds per-channel capture-done interrupt enables, channels 0..7.
// RL6: enable-low register for filter channels 0..31 sits at offset 0x12c.
// RL7: irq asserts when any flag and its enable are set; masking keeps flags.
package tfieb_pkg;
	localparam int TFIEB_ADDR_W = 12;
	localparam int TFIEB_DATA_W = 32;
	localparam int TFIEB_FILT_CH = 64;
	localparam int TFIEB_CREF_CH = 8;
	localparam logic [11:0] TFIEB_OFS_FAULT_EN_LO = 12'h12c;
	localparam logic [11:0] TFIEB_OFS_FAULT_EN_HI = 12'h130;
	localparam logic [11:0] TFIEB_OFS_CREF_STS = 12'h134;
	localparam logic [11:0] TFIEB_OFS_CREF_EN = 12'h138;
	localparam logic [31:0] TFIEB_RST_WORD = 32'h0000_0000;
	localparam logic [7:0] TFIEB_RST_CREF = 8'h00;
	localparam logic [23:0] TFIEB_RSVD_ZERO = 24'h000000;
	localparam int TFIEB_TRANS_ACT_BIT = 1;
	localparam logic TFIEB_RESP_OKAY = 1'b0;

	typedef struct packed {
		logic sel;
		logic [1:0] trans;
		logic write;
		logic ready;
		logic [11:0] addr;
	} tfieb_bus_req_t;
endpackage : tfieb_pkg

// *** hw/tfieb_bank.sv ***
// filter error enables and clock reference capture flags with irq output
// assumes a zero-wait 32-bit host slave; capture pulses come from same-clock logic
module tfieb_bank
	import tfieb_pkg::*;
(
	input wire logic MCLK_IN,
	input wire logic RST_IN,
	input wire logic HSEL_IN,
	input wire logic [11:0] HADDR_IN,
	input wire logic [1:0] HTRANS_IN,
	input wire logic HWRITE_IN,
	input wire logic HREADY_IN,
	input wire logic [31:0] HWDATA_IN,
	output logic [31:0] HRDATA_OUT,
	output logic HREADYOUT_OUT,
	output logic HRESP_OUT,
	input wire logic [7:0] CLOCK_REF_CAPTURE_DONE_IN,
	input wire logic [63:0] FILTER_FAULT_STS_IN,
	output logic [63:0] FILTER_FAULT_IRQ_EN_OUT,
	output logic IRQ_OUT
);
	tfieb_bus_req_t req;
	logic acc;
	logic wr_pend_r;
	logic wr_pend_nxt;
	logic [11:0] wr_addr_r;
	logic [11:0] wr_addr_nxt;
	logic [31:0] fault_en_lo_r;
	logic [31:0] fault_en_lo_nxt;
	logic [31:0] fault_en_hi_r;
	logic [31:0] fault_en_hi_nxt;
	logic [7:0] cref_sts_r;
	logic [7:0] cref_sts_nxt;
	logic [7:0] cref_en_r;
	logic [7:0] cref_en_nxt;
	logic [7:0] cref_clr;
	logic [31:0] rdata_r;
	logic [31:0] rdata_nxt;
	logic irq_r;
	logic irq_nxt;

	assign req = '{sel: HSEL_IN, trans: HTRANS_IN, write: HWRITE_IN,
		ready: HREADY_IN, addr: HADDR_IN};
	assign acc = req.sel && req.trans[TFIEB_TRANS_ACT_BIT] && req.ready;

	always_comb
	begin
		wr_pend_nxt = acc && req.write;
		wr_addr_nxt = acc ? req.addr : wr_addr_r;
		fault_en_lo_nxt = fault_en_lo_r;
		fault_en_hi_nxt = fault_en_hi_r;
		cref_en_nxt = cref_en_r;
		cref_clr = TFIEB_RST_CREF;
		if (wr_pend_r)
		begin
			case (wr_addr_r)
				TFIEB_OFS_FAULT_EN_LO: fault_en_lo_nxt = HWDATA_IN; // [RL1] [RL6]
				TFIEB_OFS_FAULT_EN_HI: fault_en_hi_nxt = HWDATA_IN; // [RL2]
				TFIEB_OFS_CREF_STS: cref_clr = HWDATA_IN[TFIEB_CREF_CH-1:0]; // [RL3]
				TFIEB_OFS_CREF_EN: cref_en_nxt = HWDATA_IN[TFIEB_CREF_CH-1:0]; // [RL5] [RL4]
				default: cref_clr = TFIEB_RST_CREF;
			endcase
		end
		// a capture in the clearing cycle survives
		cref_sts_nxt = (cref_sts_r & ~cref_clr) | CLOCK_REF_CAPTURE_DONE_IN; // [RL3]
		rdata_nxt = rdata_r;
		if (acc && !req.write)
		begin
			// read from next values so a write just before is seen
			case (req.addr)
				TFIEB_OFS_FAULT_EN_LO: rdata_nxt = fault_en_lo_nxt;
				TFIEB_OFS_FAULT_EN_HI: rdata_nxt = fault_en_hi_nxt;
				TFIEB_OFS_CREF_STS: rdata_nxt = {TFIEB_RSVD_ZERO, cref_sts_nxt}; // [RL4]
				TFIEB_OFS_CREF_EN: rdata_nxt = {TFIEB_RSVD_ZERO, cref_en_nxt}; // [RL4]
				default: rdata_nxt = TFIEB_RST_WORD;
			endcase
		end
		// masking gates only the output, flags stay
		irq_nxt = (|(cref_sts_nxt & cref_en_nxt))
			|| (|(FILTER_FAULT_STS_IN & {fault_en_hi_nxt, fault_en_lo_nxt})); // [RL7]
	end

	always_ff @(posedge MCLK_IN)
	begin
		if (RST_IN)
		begin
			wr_pend_r <= 1'b0;
			wr_addr_r <= 12'h000;
			fault_en_lo_r <= TFIEB_RST_WORD;
			fault_en_hi_r <= TFIEB_RST_WORD;
			cref_sts_r <= TFIEB_RST_CREF;
			cref_en_r <= TFIEB_RST_CREF;
			rdata_r <= TFIEB_RST_WORD;
			irq_r <= 1'b0;
		end
		else
		begin
			wr_pend_r <= wr_pend_nxt;
			wr_addr_r <= wr_addr_nxt;
			fault_en_lo_r <= fault_en_lo_nxt;
			fault_en_hi_r <= fault_en_hi_nxt;
			cref_sts_r <= cref_sts_nxt;
			cref_en_r <= cref_en_nxt;
			rdata_r <= rdata_nxt;
			irq_r <= irq_nxt;
		end
	end

	assign HRDATA_OUT = rdata_r;
	assign HREADYOUT_OUT = 1'b1;
	assign HRESP_OUT = TFIEB_RESP_OKAY;
	assign FILTER_FAULT_IRQ_EN_OUT = {fault_en_hi_r, fault_en_lo_r};
	assign IRQ_OUT = irq_r;

	default clocking cb @(posedge MCLK_IN);
	endclocking
	default disable iff (RST_IN);

	chk_en_lo_write: assert property ( // [RL1] [RL6]
		wr_pend_r && wr_addr_r == TFIEB_OFS_FAULT_EN_LO |=> fault_en_lo_r == $past(HWDATA_IN))
		else $error("low fault enable not written");
	chk_en_hi_write: assert property ( // [RL2]
		wr_pend_r && wr_addr_r == TFIEB_OFS_FAULT_EN_HI
		|=> FILTER_FAULT_IRQ_EN_OUT[63:32] == $past(HWDATA_IN))
		else $error("high fault enable not written");
	chk_flag_set: assert property ( // [RL3]
		|CLOCK_REF_CAPTURE_DONE_IN
		|=> (cref_sts_r & $past(CLOCK_REF_CAPTURE_DONE_IN)) == $past(CLOCK_REF_CAPTURE_DONE_IN))
		else $error("capture flag not set");
	chk_flag_clear: assert property ( // [RL3]
		wr_pend_r && wr_addr_r == TFIEB_OFS_CREF_STS
		|=> cref_sts_r == (($past(cref_sts_r) & ~$past(HWDATA_IN[7:0]))
			| $past(CLOCK_REF_CAPTURE_DONE_IN)))
		else $error("write one to clear wrong");
	chk_reserved_zero: assert property ( // [RL4]
		acc && !req.write && (req.addr == TFIEB_OFS_CREF_STS || req.addr == TFIEB_OFS_CREF_EN)
		|=> HRDATA_OUT[31:8] == TFIEB_RSVD_ZERO)
		else $error("reserved bits not zero");
	chk_cref_en_write: assert property ( // [RL5]
		wr_pend_r && wr_addr_r == TFIEB_OFS_CREF_EN
		|=> cref_en_r == $past(HWDATA_IN[TFIEB_CREF_CH-1:0]))
		else $error("capture enable not written");
	chk_cref_en_read: assert property ( // [RL5] [RL4]
		acc && !req.write && req.addr == TFIEB_OFS_CREF_EN
		|=> HRDATA_OUT == {TFIEB_RSVD_ZERO, cref_en_r})
		else $error("capture enable read back wrong");
	chk_irq_level: assert property ( // [RL7]
		##1 IRQ_OUT == ((|(cref_sts_r & cref_en_r))
			|| (|($past(FILTER_FAULT_STS_IN) & FILTER_FAULT_IRQ_EN_OUT))))
		else $error("irq does not follow flags and enables");
	chk_mask_keeps: assert property ( // [RL7]
		wr_pend_r && wr_addr_r == TFIEB_OFS_CREF_EN
		|=> cref_sts_r == ($past(cref_sts_r) | $past(CLOCK_REF_CAPTURE_DONE_IN)))
		else $error("masking changed a flag");
	chk_cref_sts_read: assert property ( // [RL3] [RL4]
		acc && !req.write && req.addr == TFIEB_OFS_CREF_STS
		|=> HRDATA_OUT == {TFIEB_RSVD_ZERO, cref_sts_r})
		else $error("capture status read back wrong");
	chk_en_lo_read: assert property ( // [RL1] [RL6]
		acc && !req.write && req.addr == TFIEB_OFS_FAULT_EN_LO
		|=> HRDATA_OUT == FILTER_FAULT_IRQ_EN_OUT[31:0])
		else $error("low fault enable read back wrong");
	chk_en_hi_read: assert property ( // [RL2]
		acc && !req.write && req.addr == TFIEB_OFS_FAULT_EN_HI
		|=> HRDATA_OUT == FILTER_FAULT_IRQ_EN_OUT[63:32])
		else $error("high fault enable read back wrong");
	chk_unmapped_read: assert property (
		acc && !req.write && req.addr != TFIEB_OFS_FAULT_EN_LO
		&& req.addr != TFIEB_OFS_FAULT_EN_HI && req.addr != TFIEB_OFS_CREF_STS
		&& req.addr != TFIEB_OFS_CREF_EN |=> HRDATA_OUT == TFIEB_RST_WORD)
		else $error("unmapped offset read not zero");
	chk_reset_clear: assert property ( // [RL1] [RL2] [RL4]
		$past(RST_IN) |-> FILTER_FAULT_IRQ_EN_OUT == {TFIEB_RST_WORD, TFIEB_RST_WORD}
		&& cref_sts_r == TFIEB_RST_CREF && cref_en_r == TFIEB_RST_CREF
		&& !IRQ_OUT && HRDATA_OUT == TFIEB_RST_WORD)
		else $error("register not cleared by reset");
	chk_ready_gate: assert property (
		!req.ready |=> !wr_pend_r)
		else $error("write taken while bus not ready");
	chk_hold_enables: assert property ( // [RL1] [RL2]
		!(wr_pend_r && (wr_addr_r == TFIEB_OFS_FAULT_EN_LO
		|| wr_addr_r == TFIEB_OFS_FAULT_EN_HI)) |=> $stable(FILTER_FAULT_IRQ_EN_OUT))
		else $error("fault enable changed without a write");
	chk_hold_cref_en: assert property ( // [RL5]
		!(wr_pend_r && wr_addr_r == TFIEB_OFS_CREF_EN) |=> $stable(cref_en_r))
		else $error("capture enable changed without a write");
	chk_rdata_hold: assert property (
		!(acc && !req.write) |=> $stable(HRDATA_OUT))
		else $error("read data changed outside a read");
	chk_irq_quiet: assert property ( // [RL7]
		!wr_pend_r && cref_en_r == TFIEB_RST_CREF
		&& FILTER_FAULT_IRQ_EN_OUT == {TFIEB_RST_WORD, TFIEB_RST_WORD} |=> !IRQ_OUT)
		else $error("irq raised with every enable off");

	// per capture channel: clear, set beats clear, hold, irq raise
	for (genvar ch = 0; ch < TFIEB_CREF_CH; ch++)
	begin : g_cref_chk
		chk_chan_clear: assert property ( // [RL3]
			wr_pend_r && wr_addr_r == TFIEB_OFS_CREF_STS && HWDATA_IN[ch]
			&& !CLOCK_REF_CAPTURE_DONE_IN[ch] |=> !cref_sts_r[ch])
			else $error("capture flag not cleared");
		chk_chan_wins: assert property ( // [RL3]
			wr_pend_r && wr_addr_r == TFIEB_OFS_CREF_STS && HWDATA_IN[ch]
			&& CLOCK_REF_CAPTURE_DONE_IN[ch] |=> cref_sts_r[ch])
			else $error("capture lost to a clear");
		chk_chan_hold: assert property ( // [RL3] [RL7]
			!CLOCK_REF_CAPTURE_DONE_IN[ch]
			&& !(wr_pend_r && wr_addr_r == TFIEB_OFS_CREF_STS && HWDATA_IN[ch])
			|=> $stable(cref_sts_r[ch]))
			else $error("capture flag changed on its own");
		chk_chan_raise: assert property ( // [RL5] [RL7]
			cref_sts_r[ch] && cref_en_r[ch] && !wr_pend_r |=> IRQ_OUT)
			else $error("enabled capture flag did not raise irq");
	end

	// per filter channel: enabled fault raises irq
	for (genvar fc = 0; fc < TFIEB_FILT_CH; fc++)
	begin : g_fault_chk
		chk_fault_raise: assert property ( // [RL7]
			FILTER_FAULT_STS_IN[fc] && FILTER_FAULT_IRQ_EN_OUT[fc] && !wr_pend_r |=> IRQ_OUT)
			else $error("enabled filter fault did not raise irq");
	end
endmodule : tfieb_bank

// *** sim/tb_tfieb_bank.sv ***
// bench for the filter interrupt enable bank
// drives host slave and event inputs at the falling clock edge
module tb_tfieb_bank
	import tfieb_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk, rst, hrdy, sel, wr, hro, hre, irq;
	logic [1:0] tr;
	logic [11:0] adr;
	logic [31:0] wd, rdat;
	logic [7:0] cap;
	logic [63:0] fsts, fen;
	int error_cnt, n_compared;
	tfieb_bank dut_u (.MCLK_IN(clk), .RST_IN(rst), .HSEL_IN(sel), .HADDR_IN(adr),
		.HTRANS_IN(tr), .HWRITE_IN(wr), .HREADY_IN(hrdy), .HWDATA_IN(wd),
		.HRDATA_OUT(rdat), .HREADYOUT_OUT(hro), .HRESP_OUT(hre),
		.CLOCK_REF_CAPTURE_DONE_IN(cap), .FILTER_FAULT_STS_IN(fsts),
		.FILTER_FAULT_IRQ_EN_OUT(fen), .IRQ_OUT(irq));
	initial
	begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	task wrap_up;
		$display("compared %0d mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : wrap_up
	task chk(input string nm, input logic [63:0] e, input logic [63:0] g);
		n_compared++;
		if (g !== e)
		begin
			error_cnt++;
			$display("unexpected %s exp %h got %h", nm, e, g);
		end
	endtask : chk
	task wr32(input logic [11:0] a, input logic [31:0] d);
		@(negedge clk);
		{sel, tr, wr, adr} = {1'b1, 2'h2, 1'b1, a};
		@(negedge clk);
		{sel, tr, wd} = {1'b0, 2'h0, d};
	endtask : wr32
	task rd32(input logic [11:0] a, input logic [31:0] e);
		@(negedge clk);
		{sel, tr, wr, adr} = {1'b1, 2'h2, 1'b0, a};
		@(negedge clk);
		{sel, tr} = 3'h0;
		chk("rdata", {32'h0, e}, {32'h0, rdat});
	endtask : rd32
	task t_reset;
		rd32(12'h12c, 32'h0);
		rd32(12'h130, 32'h0);
		rd32(12'h134, 32'h0);
		rd32(12'h138, 32'h0);
		chk("ready_resp", 64'h2, {hro, hre});
	endtask : t_reset
	task t_enables;
		wr32(12'h12c, 32'hffffffff);
		rd32(12'h12c, 32'hffffffff);
		wr32(12'h130, 32'h80000001);
		rd32(12'h130, 32'h80000001);
		chk("fen", 64'h80000001ffffffff, fen);
		wr32(12'h138, 32'hffffffff);
		rd32(12'h138, 32'h000000ff);
		wr32(12'h200, 32'h12345678);
		rd32(12'h200, 32'h0);
		chk("resp_unmapped", 64'h2, {hro, hre});
		rd32(12'h12c, 32'hffffffff);
		chk("irq_idle", 64'h0, {63'h0, irq});
	endtask : t_enables
	task t_capture;
		@(negedge clk);
		cap = 8'h81;
		@(negedge clk);
		cap = 8'h00;
		rd32(12'h134, 32'h81);
		chk("irq_set", 64'h1, {63'h0, irq});
		wr32(12'h138, 32'h0);
		rd32(12'h134, 32'h81);
		chk("irq_mask", 64'h0, {63'h0, irq});
		wr32(12'h134, 32'h01);
		rd32(12'h134, 32'h80);
	endtask : t_capture
	task t_set_wins;
		wr32(12'h138, 32'h000000ff);
		@(negedge clk);
		cap = 8'h03;
		@(negedge clk);
		cap = 8'h00;
		rd32(12'h134, 32'h83);
		wr32(12'h134, 32'h03);
		cap = 8'h01;
		@(negedge clk);
		cap = 8'h00;
		rd32(12'h134, 32'h81);
		chk("irq_wins", 64'h1, {63'h0, irq});
	endtask : t_set_wins
	task t_ready_low;
		hrdy = 1'h0;
		wr32(12'h12c, 32'h0);
		hrdy = 1'h1;
		rd32(12'h12c, 32'hffffffff);
	endtask : t_ready_low
	task t_back_to_back;
		@(negedge clk);
		{sel, tr, wr, adr} = {1'h1, 2'h2, 1'h1, 12'h130};
		@(negedge clk);
		{wr, wd} = {1'h0, 32'h00005a5a};
		@(negedge clk);
		{sel, tr} = 3'h0;
		chk("rdata_b2b", 64'h00005a5a, {32'h0, rdat});
		chk("fen_b2b", 64'h00005a5affffffff, fen);
	endtask : t_back_to_back
	task t_mid_reset;
		@(negedge clk);
		rst = 1'h1;
		repeat (2) @(negedge clk);
		rst = 1'h0;
		chk("fen_rst", 64'h0, fen);
		chk("irq_rst", 64'h0, {63'h0, irq});
		rd32(12'h134, 32'h0);
		rd32(12'h138, 32'h0);
		rd32(12'h130, 32'h0);
	endtask : t_mid_reset
	task t_fault;
		fsts = 64'h8000000000000000;
		repeat (2) @(negedge clk);
		chk("irq_fault", 64'h1, {63'h0, irq});
		wr32(12'h130, 32'h0);
		rd32(12'h130, 32'h0);
		chk("irq_off", 64'h0, {63'h0, irq});
	endtask : t_fault
	initial
	begin
		{rst, hrdy, sel, wr, tr, adr, wd, cap, fsts} = {2'h3, 120'h0};
		repeat (4) @(posedge clk);
		@(negedge clk);
		rst = 1'b0;
		t_reset();
		t_enables();
		t_capture();
		t_fault();
		t_ready_low();
		t_back_to_back();
		t_set_wins();
		t_mid_reset();
		wrap_up();
	end
	initial
	begin
		#100000;
		error_cnt++;
		wrap_up();
	end
endmodule : tb_tfieb_bank
